// ---- lcdc_pkg.sv ----
package lcdc_pkg;

  // Timing of the internal reset command sequence.
  localparam int CLK_PERIOD_NS    = 20;
  localparam int RESET_CMD_NS     = 200;
  localparam int RESET_CMD_CYCLES =
    (RESET_CMD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CNT_W      = 8;

  // Display RAM geometry and buffering.
  localparam int FIFO_DEPTH = 16;
  localparam int NUM_COLS   = 80;
  localparam int NUM_PAGES  = 4;
  localparam int RAM_WORDS  = NUM_COLS * NUM_PAGES;
  localparam int RAM_AW     = 9;

  // Row end and values after reset.
  localparam logic [6:0] COL_LIMIT      = 7'h50;
  localparam logic [6:0] COL_RST        = 7'h00;
  localparam logic [1:0] PAGE_RST       = 2'h0;
  localparam logic [4:0] START_LINE_RST = 5'h01;
  localparam logic       DISP_ON_RST    = 1'b0;
  localparam logic       STATIC_RST     = 1'b0;
  localparam logic       DUTY4_RST      = 1'b1;
  localparam logic       SEG_NORMAL_RST = 1'b1;

  // Command codes and the bits that must match.
  localparam logic [7:0] CMD_DISPLAY  = 8'hAE;
  localparam logic [7:0] CMD_START    = 8'hC0;
  localparam logic [7:0] CMD_PAGE     = 8'hB8;
  localparam logic [7:0] CMD_COLUMN   = 8'h00;
  localparam logic [7:0] CMD_SEG_DIR  = 8'hA0;
  localparam logic [7:0] CMD_STATIC   = 8'hA4;
  localparam logic [7:0] CMD_DUTY     = 8'hA8;
  localparam logic [7:0] CMD_RMW      = 8'hE0;
  localparam logic [7:0] CMD_END      = 8'hEE;
  localparam logic [7:0] CMD_RESET    = 8'hE2;
  localparam logic [7:0] MASK_BIT0    = 8'hFE;
  localparam logic [7:0] MASK_START   = 8'hE0;
  localparam logic [7:0] MASK_PAGE    = 8'hFC;
  localparam logic [7:0] MASK_COLUMN  = 8'h80;
  localparam logic [7:0] MASK_FULL    = 8'hFF;

  // Status byte bit positions.
  localparam int ST_BUSY_BIT  = 7;
  localparam int ST_ADC_BIT   = 6;
  localparam int ST_OFF_BIT   = 5;
  localparam int ST_RESET_BIT = 4;

  // Host pin vector layout and its idle level.
  localparam int          PIN_W    = 11;
  localparam int          PIN_SEL  = 10;
  localparam int          PIN_RD   = 9;
  localparam int          PIN_WR   = 8;
  localparam logic [10:0] PIN_IDLE = 11'h300;

  typedef enum logic [1:0] {OP_CMD, OP_DATA_WR, OP_DATA_RD} lcdc_op_e;
  typedef enum logic {ST_IDLE, ST_RESET} lcdc_exec_e;

  typedef struct packed {
    lcdc_op_e   op;
    logic [7:0] value;
  } lcdc_req_s;

  typedef struct packed {
    logic       displayActive;
    logic       allCommons;
    logic       duty4;
    logic       segNormal;
    logic       powerSave;
    logic [4:0] startLine;
  } lcdc_drive_s;

endpackage

// ---- lcdc_fifo.sv ----
`timescale 1ns/100ps
module lcdc_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,      // System clock.
  input  wire logic             rst,      // Asynchronous reset, high.
  input  wire logic [WIDTH-1:0] inData,   // Word to store.
  input  wire logic             inValid,  // Source offers a word.
  output logic                  inReady,  // Room for a word.
  output logic [WIDTH-1:0]      outData,  // Oldest stored word.
  output logic                  outValid, // A word is stored.
  input  wire logic             outReady  // Sink takes the word.
);

  localparam int AW = $clog2(DEPTH);

  // Pointers wrap by overflow, so only powers of two are served.
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
  begin : g_bad_param
    $error("lcdc_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  // Honest flags come straight from the occupancy count.
  assign inReady  = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData  = mem_q[rdPtr_q];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  // Storage holds data only, so it needs no reset.
  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wrPtr_q] <= inData;
  end

  // Pointer and count bookkeeping.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
        wrPtr_q <= wrPtr_q + 1'b1;
      if (pop)
        rdPtr_q <= rdPtr_q + 1'b1;
      if (push && !pop)
        count_q <= count_q + 1'b1;
      else if (pop && !push)
        count_q <= count_q - 1'b1;
    end
  end

endmodule // lcdc_fifo

// ---- lcdc_cmd_decoder.sv ----
`timescale 1ns/100ps
module lcdc_cmd_decoder
  import lcdc_pkg::*;
#(
  parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
  input  wire logic        clk,            // System clock, 50 MHz.
  input  wire logic        rst,            // Hardware reset, async, high.
  input  wire logic [7:0]  hostDataIn,     // Host data bus, inbound.
  input  wire logic        cmdDataSelect,  // Low command, high data.
  input  wire logic        rdStrobe_n,     // Host read strobe.
  input  wire logic        wrStrobe_n,     // Host write strobe.
  output logic [7:0]       hostDataOut_q,  // Host data bus, outbound.
  output logic             hostDataOe_n_q, // Low while driving the bus.
  input  wire logic [1:0]  scanPage,       // Drive timing RAM page.
  input  wire logic [6:0]  scanCol,        // Drive timing RAM column.
  output logic [7:0]       scanData_q,     // RAM byte for the scan.
  output lcdc_drive_s      driveCfg_q,     // Drive mode settings.
  output logic             oscOutOe_n_q    // High floats oscillator out.
);

  if (RESET_CMD_CYCLES < 1 || RESET_CMD_CYCLES > 255)
  begin : g_bad_reset
    $error("lcdc_cmd_decoder: reset command length out of range");
  end

  localparam int REQ_W = $bits(lcdc_req_s);

  logic [PIN_W-1:0] pinsRaw;
  logic [PIN_W-1:0] sync1_q;
  logic [PIN_W-1:0] sync2_q;
  logic [PIN_W-1:0] sync3_q;
  logic [PIN_W-1:0] pins_q;
  logic [PIN_W-1:0] pinAgree;
  logic             prevRd_q;
  logic             prevWr_q;
  logic             rdFall;
  logic             rdRise;
  logic             wrRise;
  logic             holdSel_q;
  logic [7:0]       holdByte_q;
  logic             readSel_q;
  lcdc_req_s        fifoIn;
  logic             fifoInValid;
  logic             fifoInReady;
  logic [REQ_W-1:0] fifoOutData;
  logic             fifoOutValid;
  logic             fifoOutReady;
  lcdc_req_s        req;
  lcdc_exec_e       state_q;
  logic [RESET_CNT_W-1:0] resetCnt_q;
  logic             exec;
  logic             isCmd;
  logic             isWr;
  logic             isRd;
  logic             resetting;
  logic             busy;
  logic [7:0]       statusByte;
  logic             displayOn_q;
  logic             staticDrive_q;
  logic             duty4_q;
  logic             segNormal_q;
  logic [4:0]       startLine_q;
  logic [1:0]       page_q;
  logic [6:0]       col_q;
  logic [6:0]       savedCol_q;
  logic             rmw_q;
  logic [7:0]       readLatch_q;
  logic [7:0]       ram_q [RAM_WORDS];
  logic             cDisp, cStart, cPage, cCol, cSeg, cStatic;
  logic             cDuty, cRmw, cEnd, cReset;

  // True when the byte matches the code in every masked bit.
  function automatic logic codeIs(input logic [7:0] b,
                                  input logic [7:0] code,
                                  input logic [7:0] mask);
    return (b & mask) == (code & mask);
  endfunction

  // Column step that stops at the end of the row.
  function automatic logic [6:0] colNext(input logic [6:0] c);
    return (c < COL_LIMIT) ? c + 7'h01 : c;
  endfunction

  // Flat RAM index; used by host access and by the scan port.
  function automatic logic [RAM_AW-1:0] ramIndex(input logic [1:0] p,
                                                 input logic [6:0] c);
    return RAM_AW'(p) * RAM_AW'(NUM_COLS) + RAM_AW'(c);
  endfunction

  // Host pins arrive unsynchronised; a bit moves once stages 2 and 3 agree.
  assign pinsRaw  = {cmdDataSelect, rdStrobe_n, wrStrobe_n, hostDataIn};
  assign pinAgree = ~(sync2_q ^ sync3_q);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_q  <= PIN_IDLE;
      sync2_q  <= PIN_IDLE;
      sync3_q  <= PIN_IDLE;
      pins_q   <= PIN_IDLE;
      prevRd_q <= 1'b1;
      prevWr_q <= 1'b1;
    end
    else
    begin
      sync1_q  <= pinsRaw;
      sync2_q  <= sync1_q;
      sync3_q  <= sync2_q;
      pins_q   <= (pins_q & ~pinAgree) | (sync2_q & pinAgree);
      prevRd_q <= pins_q[PIN_RD];
      prevWr_q <= pins_q[PIN_WR];
    end
  end

  assign rdFall = ~pins_q[PIN_RD] & prevRd_q;
  assign rdRise = pins_q[PIN_RD] & ~prevRd_q;
  assign wrRise = pins_q[PIN_WR] & ~prevWr_q;

  // Data is held while the write strobe is low, since the host may
  // drop it in the same moment it releases the strobe.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      holdSel_q  <= 1'b0;
      holdByte_q <= 8'h00;
    end
    else if (!pins_q[PIN_WR])
    begin
      holdSel_q  <= pins_q[PIN_SEL];
      holdByte_q <= pins_q[7:0];
    end
  end

  // Busy covers a running reset and a full queue.
  assign resetting = (state_q == ST_RESET);
  assign busy      = resetting | ~fifoInReady;

  // Status byte; the low nibble always reads zero.
  always_comb
  begin
    statusByte               = 8'h00;
    statusByte[ST_BUSY_BIT]  = busy;
    statusByte[ST_ADC_BIT]   = segNormal_q;
    statusByte[ST_OFF_BIT]   = ~displayOn_q;
    statusByte[ST_RESET_BIT] = resetting;
  end

  // Bus driving: the answer is chosen by the select line at the fall.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hostDataOut_q  <= 8'h00;
      hostDataOe_n_q <= 1'b1;
      readSel_q      <= 1'b0;
    end
    else if (rdFall)
    begin
      hostDataOut_q  <= pins_q[PIN_SEL] ? readLatch_q : statusByte;
      hostDataOe_n_q <= 1'b0;
      readSel_q      <= pins_q[PIN_SEL];
    end
    else if (rdRise)
      hostDataOe_n_q <= 1'b1;
  end

  // Writes are refused while busy; a data read queues its latch refill.
  always_comb
  begin
    fifoInValid  = 1'b0;
    fifoIn.op    = OP_CMD;
    fifoIn.value = 8'h00;
    if (wrRise && !busy)
    begin
      fifoInValid  = 1'b1;
      fifoIn.op    = holdSel_q ? OP_DATA_WR : OP_CMD;
      fifoIn.value = holdByte_q;
    end
    else if (rdRise && readSel_q)
    begin
      fifoInValid  = 1'b1;
      fifoIn.op    = OP_DATA_RD;
    end
  end

  lcdc_fifo #(
    .WIDTH (REQ_W),
    .DEPTH (FIFO_DEPTH_P)
  ) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .inData   (fifoIn),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .outData  (fifoOutData),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady)
  );

  // One queued request executes per cycle; a reset stalls the queue.
  assign fifoOutReady = (state_q == ST_IDLE);
  assign exec         = fifoOutValid & fifoOutReady;
  assign req          = lcdc_req_s'(fifoOutData);
  assign isCmd        = exec && (req.op == OP_CMD);
  assign isWr         = exec && (req.op == OP_DATA_WR);
  assign isRd         = exec && (req.op == OP_DATA_RD);

  // Command decode; bytes matching nothing leave all state alone.
  assign cDisp   = isCmd && codeIs(req.value, CMD_DISPLAY, MASK_BIT0);
  assign cStart  = isCmd && codeIs(req.value, CMD_START, MASK_START);
  assign cPage   = isCmd && codeIs(req.value, CMD_PAGE, MASK_PAGE);
  assign cCol    = isCmd && codeIs(req.value, CMD_COLUMN, MASK_COLUMN);
  assign cSeg    = isCmd && codeIs(req.value, CMD_SEG_DIR, MASK_BIT0);
  assign cStatic = isCmd && codeIs(req.value, CMD_STATIC, MASK_BIT0);
  assign cDuty   = isCmd && codeIs(req.value, CMD_DUTY, MASK_BIT0);
  assign cRmw    = isCmd && codeIs(req.value, CMD_RMW, MASK_FULL);
  assign cEnd    = isCmd && codeIs(req.value, CMD_END, MASK_FULL);
  assign cReset  = isCmd && codeIs(req.value, CMD_RESET, MASK_FULL);

  // Reset command sequencer.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q    <= ST_IDLE;
      resetCnt_q <= '0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          if (cReset)
          begin
            state_q    <= ST_RESET;
            resetCnt_q <= RESET_CNT_W'(RESET_CMD_CYCLES - 1);
          end
        ST_RESET:
          if (resetCnt_q == '0)
            state_q <= ST_IDLE;
          else
            resetCnt_q <= resetCnt_q - 1'b1;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Mode settings; the reset command leaves these alone.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      displayOn_q   <= DISP_ON_RST;
      staticDrive_q <= STATIC_RST;
      duty4_q       <= DUTY4_RST;
      segNormal_q   <= SEG_NORMAL_RST;
    end
    else
    begin
      if (cDisp)
        displayOn_q <= req.value[0];
      if (cStatic)
        staticDrive_q <= req.value[0];
      if (cDuty)
        duty4_q <= req.value[0];
      if (cSeg)
        segNormal_q <= ~req.value[0];
    end
  end

  // Start line and page; the page steers host access only.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      startLine_q <= START_LINE_RST;
      page_q      <= PAGE_RST;
    end
    else if (cReset)
    begin
      startLine_q <= START_LINE_RST;
      page_q      <= PAGE_RST;
    end
    else
    begin
      if (cStart)
        startLine_q <= req.value[4:0];
      if (cPage)
        page_q <= req.value[1:0];
    end
  end

  // Column counter and read-modify-write bookkeeping. The page is
  // never touched here, so a full row cannot spill into the next.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      col_q      <= COL_RST;
      savedCol_q <= COL_RST;
      rmw_q      <= 1'b0;
    end
    else if (cReset)
    begin
      col_q <= COL_RST;
      rmw_q <= 1'b0;
    end
    else if (cCol)
      col_q <= req.value[6:0];
    else if (cRmw)
    begin
      rmw_q      <= 1'b1;
      savedCol_q <= col_q;
    end
    else if (cEnd)
    begin
      rmw_q <= 1'b0;
      if (rmw_q)
        col_q <= savedCol_q;
    end
    else if (isWr || (isRd && !rmw_q))
      col_q <= colNext(col_q);
  end

  // Display RAM; only host data writes change it.
  always_ff @(posedge clk)
  begin
    if (isWr && col_q < COL_LIMIT)
      ram_q[ramIndex(page_q, col_q)] <= req.value;
  end

  // Output latch refilled after each data read.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      readLatch_q <= 8'h00;
    else if (isRd)
      readLatch_q <= (col_q < COL_LIMIT) ?
                     ram_q[ramIndex(page_q, col_q)] : 8'h00;
  end

  // Scan port and drive settings for the segment and common timing.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scanData_q   <= 8'h00;
      driveCfg_q   <= '0;
      oscOutOe_n_q <= 1'b0;
    end
    else
    begin
      scanData_q <= (scanCol < COL_LIMIT) ?
                    ram_q[ramIndex(scanPage, scanCol)] : 8'h00;
      driveCfg_q.powerSave     <= staticDrive_q & ~displayOn_q;
      driveCfg_q.displayActive <= displayOn_q | staticDrive_q;
      driveCfg_q.allCommons    <= staticDrive_q;
      driveCfg_q.duty4         <= duty4_q;
      driveCfg_q.segNormal     <= segNormal_q;
      driveCfg_q.startLine     <= startLine_q;
      oscOutOe_n_q             <= staticDrive_q & ~displayOn_q;
    end
  end

  sequence s_resetCmd;
    cReset;
  endsequence

  sequence s_endInRmw;
    cEnd && rmw_q && !cReset;
  endsequence

  property p_colSaturate;
    @(posedge clk) disable iff (rst)
    col_q <= COL_LIMIT || $past(cCol);
  endproperty
  a_colSaturate: assert property (p_colSaturate)
    else $error("column passed the end of row");

  property p_pageNoCarry;
    @(posedge clk) disable iff (rst)
    (isWr || isRd) |=> $stable(page_q);
  endproperty
  a_pageNoCarry: assert property (p_pageNoCarry)
    else $error("data access changed the page");

  property p_colLoad;
    @(posedge clk) disable iff (rst)
    cCol |=> col_q == $past(req.value[6:0]);
  endproperty
  a_colLoad: assert property (p_colLoad)
    else $error("column set did not load");

  property p_resetBusy;
    @(posedge clk) disable iff (rst)
    s_resetCmd |=> (resetting && busy && !fifoOutReady)[*8];
  endproperty
  a_resetBusy: assert property (p_resetBusy)
    else $error("busy dropped during reset command");

  property p_resetValues;
    @(posedge clk) disable iff (rst)
    s_resetCmd |=> startLine_q == START_LINE_RST && col_q == COL_RST
                   && page_q == PAGE_RST && !rmw_q;
  endproperty
  a_resetValues: assert property (p_resetValues)
    else $error("reset command left a register set");

  property p_rmwReadHold;
    @(posedge clk) disable iff (rst)
    isRd && rmw_q |=> col_q == $past(col_q);
  endproperty
  a_rmwReadHold: assert property (p_rmwReadHold)
    else $error("read moved column in rmw mode");

  property p_endRestore;
    @(posedge clk) disable iff (rst)
    s_endInRmw |=> col_q == $past(savedCol_q) && !rmw_q;
  endproperty
  a_endRestore: assert property (p_endRestore)
    else $error("end did not restore the column");

  property p_statusRead;
    @(posedge clk) disable iff (rst)
    rdFall && !pins_q[PIN_SEL] |=> !hostDataOe_n_q
      && hostDataOut_q[3:0] == 4'h0
      && hostDataOut_q[ST_BUSY_BIT] == $past(busy)
      && hostDataOut_q[ST_OFF_BIT] == $past(!displayOn_q);
  endproperty
  a_statusRead: assert property (p_statusRead)
    else $error("status byte wrong");

  property p_saveExit;
    @(posedge clk) disable iff (rst)
    (cDisp && req.value[0]) |=> ##1 !driveCfg_q.powerSave;
  endproperty
  a_saveExit: assert property (p_saveExit)
    else $error("power save kept after display on");

endmodule // lcdc_cmd_decoder

// ---- lcdc_host_model.sv ----
`timescale 1ns/100ps
// Host processor on the parallel port. Strobes are held well past the
// three-cycle input filter, so no transfer is lost to it.
module lcdc_host_model (
  input  wire logic       clk,           // System clock.
  output logic [7:0]      hostDataIn,    // Data toward the device.
  output logic            cmdDataSelect, // Low command, high data.
  output logic            rdStrobe_n,    // Read strobe.
  output logic            wrStrobe_n,    // Write strobe.
  input  wire logic [7:0] hostDataOut_q, // Data from the device.
  input  wire logic       hostDataOe_n_q // Low while device drives.
);
  // The bus idles with both strobes high and select low.
  initial
  begin
    hostDataIn    = 8'h00;
    cmdDataSelect = 1'b0;
    rdStrobe_n    = 1'b1;
    wrStrobe_n    = 1'b1;
  end

  // One write. The byte is then inverted, so a stale value never passes.
  task automatic wr(input logic sel, input logic [7:0] val, input int gap);
    @(posedge clk);
    #1;
    cmdDataSelect = sel;
    hostDataIn    = val;
    wrStrobe_n    = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    wrStrobe_n = 1'b1;
    repeat (gap) @(posedge clk);
    #1;
    hostDataIn = ~val;
  endtask

  // One read. The answer is taken while the strobe is still low.
  task automatic rd(input logic sel, output logic [8:0] r);
    @(posedge clk);
    #1;
    cmdDataSelect = sel;
    rdStrobe_n    = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    r          = {hostDataOe_n_q, hostDataOut_q};
    rdStrobe_n = 1'b1;
    repeat (10) @(posedge clk);
    #1;
  endtask
endmodule // lcdc_host_model

// ---- tb.sv ----
`timescale 1ns/100ps
module tb;
  import lcdc_pkg::*;
  logic        clk, rst, cmdDataSelect, rdStrobe_n, wrStrobe_n;
  logic        hostDataOe_n_q, oscOutOe_n_q, dOn, stat, duty4, segN;
  logic [7:0]  hostDataIn, hostDataOut_q, scanData_q, v;
  logic [1:0]  scanPage;
  logic [6:0]  scanCol;
  logic [4:0]  line;
  logic [8:0]  r;
  logic [7:0]  ram [0:319];
  lcdc_drive_s driveCfg_q;
  int          errTotal, nTests, col;
  integer      seed = 32'hf88a;
  logic [7:0]  codes [8] = '{8'hAE, 8'hA0, 8'hA4, 8'hA8, 8'hC0, 8'hB8,
                             8'hA2, 8'hE1};
  logic [7:0]  masks [8] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h1F, 8'h03,
                             8'h00, 8'h00};
  logic [7:0]  corner [14] = '{8'hA5, 8'hA4, 8'hA5, 8'hAF, 8'hAE, 8'hA4,
    8'hA1, 8'hA0, 8'hA8, 8'hA9, 8'hDF, 8'hC1, 8'hA2, 8'hE1};

  lcdc_cmd_decoder #(.FIFO_DEPTH_P(16)) dut (.clk(clk), .rst(rst),
    .hostDataIn(hostDataIn), .cmdDataSelect(cmdDataSelect),
    .rdStrobe_n(rdStrobe_n), .wrStrobe_n(wrStrobe_n),
    .hostDataOut_q(hostDataOut_q), .hostDataOe_n_q(hostDataOe_n_q),
    .scanPage(scanPage), .scanCol(scanCol), .scanData_q(scanData_q),
    .driveCfg_q(driveCfg_q), .oscOutOe_n_q(oscOutOe_n_q));
  lcdc_host_model host (.clk(clk), .hostDataIn(hostDataIn),
    .cmdDataSelect(cmdDataSelect), .rdStrobe_n(rdStrobe_n),
    .wrStrobe_n(wrStrobe_n), .hostDataOut_q(hostDataOut_q),
    .hostDataOe_n_q(hostDataOe_n_q));

  // Free-running 50 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Any hang ends the run here as a failure.
  initial
  begin
    repeat (100000) @(posedge clk);
    errTotal++;
    completeRun();
  end

  task automatic completeRun();
    if (errTotal == 0 && nTests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(string name, logic [9:0] seen, logic [9:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Expected drive settings and status from the bench's own mode copy.
  function automatic lcdc_drive_s expCfg();
    return '{dOn | stat, stat, duty4, segN, stat & ~dOn, line};
  endfunction
  function automatic logic [7:0] expStat();
    return {1'b0, segN, ~dOn, 5'h00};
  endfunction

  task automatic cmd(input logic [7:0] b);
    host.wr(1'b0, b, 10);
  endtask
  task automatic wdat(input int p, input int c, input logic [7:0] b);
    if (c < 80)
      ram[p * 80 + c] = b;
    host.wr(1'b1, b, 10);
  endtask
  task automatic rdat(input logic sel, input logic [7:0] e, string n);
    host.rd(sel, r);
    check(n, r, {1'b0, e});
    check("oeRelease", hostDataOe_n_q, 1'b1);
  endtask
  task automatic scan(input int p, input int c, input logic [7:0] e);
    scanPage = p[1:0];
    scanCol  = c[6:0];
    repeat (2) @(posedge clk);
    #1;
    check("scanData", scanData_q, e);
  endtask

  // A mode command, then drive settings and oscillator compared, and status when not static.
  task automatic modeCmd(input logic [7:0] b);
    cmd(b);
    casez (b)
      8'b1010111?: dOn = b[0];
      8'b1010000?: segN = ~b[0];
      8'b1010010?: stat = b[0];
      8'b1010100?: duty4 = b[0];
      8'b110?????: line = b[4:0];
      default: ;
    endcase
    check("driveCfg", driveCfg_q, expCfg());
    check("oscFloat", oscOutOe_n_q, stat & ~dOn);
    if (!stat)
      rdat(1'b0, expStat(), "status");
  endtask

  initial
  begin
    rst = 1'b1;
    scanPage = 2'h0;
    scanCol = 7'h00;
    {dOn, stat, duty4, segN, line} = {4'b0011, 5'h01};
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("driveCfg", driveCfg_q, expCfg());
    rdat(1'b0, expStat(), "status");
    foreach (corner[i]) modeCmd(corner[i]);
    repeat (12)
    begin
      v = $random(seed);
      modeCmd(codes[v[2:0]] | ({$random(seed)} & masks[v[2:0]]));
    end
    // Burst write then read back at page 1 and a random column.
    col = {$random(seed)} % 76;
    cmd(8'hB9);
    cmd(col[7:0]);
    for (int i = 0; i < 4; i++) wdat(1, col + i, $random(seed));
    cmd(col[7:0]);
    host.rd(1'b1, r);
    for (int i = 0; i < 4; i++) rdat(1'b1, ram[80 + col + i], "rd");
    scan(1, col + 3, ram[80 + col + 3]);
    // Column saturation at the page end, with no carry into the page.
    cmd(8'hBB);
    cmd(8'h00);
    wdat(3, 0, $random(seed));
    cmd(8'hBA);
    cmd(8'h4F);
    wdat(2, 79, $random(seed));
    wdat(2, 80, $random(seed));
    scan(3, 0, ram[240]);
    cmd(8'h4F);
    host.rd(1'b1, r);
    rdat(1'b1, ram[239], "rd");
    rdat(1'b1, 8'h00, "rd");
    // Read-modify-write, reads hold the column and the end restores it.
    cmd(8'hB9);
    cmd(col[7:0]);
    cmd(8'hE0);
    host.rd(1'b1, r);
    rdat(1'b1, ram[80 + col], "rd");
    rdat(1'b1, ram[80 + col], "rd");
    wdat(1, col, $random(seed));
    wdat(1, col + 1, $random(seed));
    cmd(8'hEE);
    host.rd(1'b1, r);
    rdat(1'b1, ram[80 + col], "rd");
    rdat(1'b1, ram[81 + col], "rd");
    // Reset command: busy and resetting shown, RAM kept, addresses cleared.
    modeCmd(8'hD3);
    host.wr(1'b0, 8'hE2, 3);
    host.rd(1'b0, r);
    check("status", r, {1'b0, 1'b1, segN, ~dOn, 5'h10});
    line = 5'h01;
    check("driveCfg", driveCfg_q, expCfg());
    rdat(1'b0, expStat(), "status");
    wdat(0, 0, $random(seed));
    scan(0, 0, ram[0]);
    scan(1, col + 1, ram[81 + col]);
    // A command that lands while the reset command runs must be dropped.
    modeCmd(8'hC7);
    host.wr(1'b0, 8'hE2, 3);
    host.wr(1'b0, 8'hC5, 10);
    line = 5'h01;
    check("driveCfg", driveCfg_q, expCfg());
    completeRun();
  end
endmodule // tb
